// file: core/ubg_noise_filter.sv
`timescale 1ns/10ps
`default_nettype none
module ubg_noise_filter
    import ubg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic sample_tick,
    input wire logic pin_in,
    output logic level_out
);
    logic s0_r;
    logic s1_r;
    logic lvl_r;
    wire match = (s0_r == s1_r);

    // two matching samples needed, so reception lags the pin by three base clocks
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s0_r <= 1'b1;
            s1_r <= 1'b1;
            lvl_r <= 1'b1;
        end
        else if (sample_tick)
        begin
            s0_r <= pin_in;
            s1_r <= s0_r;
            if (match)
            begin
                lvl_r <= s1_r;
            end
        end
    end

    assign level_out = lvl_r;
endmodule // ubg_noise_filter
`default_nettype wire

// file: core/ubg_pkg.sv
package ubg_pkg;
    localparam int DIV_W = 8;
    localparam int SEL_W = 4;
    localparam int PRE_W = 11;
    localparam int HALF_W = 5;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'ha;
    localparam logic [7:0] RX_BUF_RESET = 8'hff;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    // half-bit counts measured from the falling edge of the start bit
    localparam logic [HALF_W-1:0] HALF_START = 5'h01;
    localparam logic [HALF_W-1:0] HALF_D_FIRST = 5'h03;
    localparam logic [HALF_W-1:0] HALF_D_LAST = 5'h11;
    localparam logic [HALF_W-1:0] HALF_PAR = 5'h13;
    localparam logic [HALF_W-1:0] HALF_STOP_NP = 5'h13;
    localparam logic [HALF_W-1:0] HALF_STOP_P = 5'h15;
    localparam logic [HALF_W-1:0] HALF_BRK_MIN = 5'h15;
    localparam logic [HALF_W-1:0] HALF_SAT = 5'h1f;
    localparam logic [3:0] TX_LAST_NP = 4'h9;
    localparam logic [3:0] TX_LAST_P = 4'ha;
    localparam int CTL_FLAG_BIT = 7;
    localparam int CTL_TRIG_BIT = 6;
    localparam int ERR_OVR_BIT = 0;
    localparam int ERR_FRM_BIT = 1;
    localparam int ERR_PAR_BIT = 2;
    localparam int RXBUF_DEPTH = 2;

    typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} ubg_parity_t;

    typedef struct packed {
        logic power;
        logic txe;
        logic rxe;
        ubg_parity_t parity;
    } ubg_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic par_err;
        logic frm_err;
    } ubg_rx_word_t;
endpackage

// file: core/ubg_skid_buf.sv
`timescale 1ns/10ps
`default_nettype none
module ubg_skid_buf
    import ubg_pkg::*;
#(
    parameter int W = 10,
    parameter int DEPTH = RXBUF_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop)
            begin
                rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // ubg_skid_buf
`default_nettype wire

// file: core/ubg_top.sv
// Overview of operation
// - break reception runs while power, receive enable and trigger bit are set.
// - break reception detects the start bit and shifts data as normally.
// - stop after a long enough break raises receive irq, clears flag and trigger.
// - no overrun, parity or framing error is flagged during break reception.
// - break reception never updates the receive buffer; it keeps its last value, FFH after reset.
// - a short break raises no irq and leaves flag and trigger set.
// - a stop later than 10.5 bits is a valid break, else a break error.
// - break flag sits at bit 7, trigger at bit 6 of the control register.
// - transmit and receive have their own 8-bit counters on one base clock.
// - base clock is chosen by the select field and held low when unpowered.
// - transmit counter is held at zero unless power and transmit enable are set.
// - transmit counter clears when the first byte enters the transmit buffer.
// - counter clears after each frame when more data waits, else keeps counting.
// - receive counter is held at zero unless power and receive enable are set.
// - receive counter runs from start bit to end of frame, then waits.
// - divisor k of 8 to 255 gives a bit rate of base clock over 2k.
// - after a falling edge, k counts later a low level confirms the start bit.
// - receive input is filtered by two matching base clock samples.
// - a break field is low for at least 13 bit times.
`timescale 1ns/10ps
`default_nettype none
module ubg_top
    import ubg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire ubg_mode_t async_mode_reg,
    input wire logic [SEL_W-1:0] base_clock_select_field,
    input wire logic [DIV_W-1:0] divisor_field,
    input wire logic break_trigger_set,
    input wire logic err_status_read,
    input wire logic tx_wr_valid,
    output logic tx_wr_ready,
    input wire logic [7:0] tx_wr_data,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    output logic base_clock,
    output logic tx_complete_irq,
    output logic rx_complete_irq,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output ubg_rx_word_t rx_out_word,
    output logic [7:0] rx_buffer_reg,
    output logic [7:0] async_control_reg,
    output logic [7:0] rx_error_status_reg
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_FRAME, RX_BRK} ubg_rx_st_t;
    typedef enum logic {TX_IDLE, TX_SEND} ubg_tx_st_t;

    function automatic logic [PRE_W-1:0] sel_mask(input logic [SEL_W-1:0] sel);
        logic [SEL_W-1:0] s;
        s = (sel > SEL_MAX) ? SEL_MAX : sel;
        sel_mask = PRE_W'((1 << s) - 1);
    endfunction

    function automatic logic par_bit(input ubg_parity_t m, input logic [7:0] d);
        par_bit = (m == PAR_ODD) ? ~(^d) : (m == PAR_EVEN) ? ^d : 1'b0;
    endfunction

    wire power = async_mode_reg.power;
    wire tx_on = power && async_mode_reg.txe;
    wire rx_on = power && async_mode_reg.rxe;
    wire par_on = (async_mode_reg.parity != PAR_NONE);

    // base clock prescaler
    logic [PRE_W-1:0] pre_r;
    wire [PRE_W-1:0] pre_mask = sel_mask(base_clock_select_field);
    wire tick = power && ((pre_r & pre_mask) == pre_mask);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_r <= '0;
        end
        else
        begin
            pre_r <= power ? pre_r + 1'b1 : '0;
        end
    end

    assign base_clock = tick;

    // receive input filter
    logic rx_lvl;
    logic rx_lvl_d_r;

    ubg_noise_filter u_filt (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .sample_tick(tick),
        .pin_in(serial_rx_pin),
        .level_out(rx_lvl)
    );

    wire rx_fall = rx_lvl_d_r && !rx_lvl;

    // break control bits
    logic brk_trig_r;
    logic brk_flag_r;
    wire brk_mode = rx_on && brk_trig_r;

    // receive side
    ubg_rx_st_t rx_st_r;
    ubg_rx_st_t rx_st_nxt;
    logic [DIV_W-1:0] rx_cnt_r;
    logic [HALF_W-1:0] rx_half_r;
    logic [7:0] rx_shift_r;
    logic rx_par_r;
    logic [7:0] rx_buf_r;
    logic ovr_r;
    logic frm_r;
    logic parerr_r;
    logic rx_irq_r;

    wire rx_run = (rx_st_r != RX_IDLE);
    // counter wraps every k base clocks, i.e. half a bit: rate = base/(2k)
    wire rx_half_end = tick && rx_run && (rx_cnt_r == divisor_field - DIV_ONE);
    wire [HALF_W-1:0] rx_half_now = rx_half_r + 1'b1;
    wire rx_samp = rx_half_end && rx_half_now[0];
    wire rx_data_pt = (rx_half_now >= HALF_D_FIRST) && (rx_half_now <= HALF_D_LAST);
    wire rx_par_pt = par_on && (rx_half_now == HALF_PAR);
    wire [HALF_W-1:0] stop_half = par_on ? HALF_STOP_P : HALF_STOP_NP;
    wire rx_stop_pt = (rx_half_now == stop_half);
    wire rx_frame_end = (rx_st_r == RX_FRAME) && rx_samp && rx_stop_pt;
    wire rx_par_bad = (rx_par_r != par_bit(async_mode_reg.parity, rx_shift_r));
    wire rx_frm_bad = !rx_lvl;
    // stop bit in break mode is the first high level after the low run
    wire brk_stop = (rx_st_r == RX_BRK) && rx_lvl;
    // halves finished before the stop edge: 21 already means later than 10.5 bits
    wire brk_valid = brk_stop && (rx_half_r >= HALF_BRK_MIN);
    wire buf_ready;
    wire push = rx_frame_end && buf_ready;
    ubg_rx_word_t push_word;

    assign push_word.data = rx_shift_r;
    assign push_word.par_err = rx_par_pt ? 1'b0 : (par_on && rx_par_bad);
    assign push_word.frm_err = rx_frm_bad;

    always_comb
    begin
        rx_st_nxt = rx_st_r;
        unique case (rx_st_r)
            RX_IDLE:
            begin
                if (rx_fall)
                begin
                    rx_st_nxt = RX_START;
                end
            end
            RX_START:
            begin
                if (rx_half_end)
                begin
                    // k counts after the edge a low level confirms the start
                    if (rx_lvl)
                    begin
                        rx_st_nxt = RX_IDLE;
                    end
                    else
                    begin
                        rx_st_nxt = brk_mode ? RX_BRK : RX_FRAME;
                    end
                end
            end
            RX_FRAME:
            begin
                if (rx_frame_end)
                begin
                    rx_st_nxt = RX_IDLE;
                end
            end
            RX_BRK:
            begin
                if (brk_stop)
                begin
                    rx_st_nxt = RX_IDLE;
                end
            end
        endcase
        if (!rx_on)
        begin
            rx_st_nxt = RX_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= '0;
            rx_half_r <= '0;
            rx_lvl_d_r <= 1'b1;
        end
        else
        begin
            rx_st_r <= rx_st_nxt;
            rx_lvl_d_r <= rx_lvl;
            if (!rx_on || rx_st_nxt == RX_IDLE)
            begin
                rx_cnt_r <= '0;
                rx_half_r <= '0;
            end
            else if (tick && rx_run)
            begin
                rx_cnt_r <= rx_half_end ? '0 : rx_cnt_r + 1'b1;
                if (rx_half_end && rx_half_r != HALF_SAT)
                begin
                    rx_half_r <= rx_half_now;
                end
            end
        end
    end

    // shift register, parity capture
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_shift_r <= RX_BUF_RESET;
            rx_par_r <= 1'b0;
        end
        else if (rx_samp && rx_data_pt && rx_st_r != RX_START)
        begin
            rx_shift_r <= {rx_lvl, rx_shift_r[7:1]};
        end
        else if (rx_samp && rx_par_pt && rx_st_r == RX_FRAME)
        begin
            rx_par_r <= rx_lvl;
        end
    end

    // receive buffer and error flags only load on normal frames; a status read clears the flags
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_buf_r <= RX_BUF_RESET;
            ovr_r <= 1'b0;
            frm_r <= 1'b0;
            parerr_r <= 1'b0;
            rx_irq_r <= 1'b0;
        end
        else
        begin
            rx_irq_r <= rx_frame_end || brk_valid;
            if (push)
            begin
                rx_buf_r <= rx_shift_r;
            end
            // a new error in the clearing cycle survives the read
            ovr_r <= (rx_frame_end && !buf_ready) || (ovr_r && !err_status_read);
            frm_r <= (rx_frame_end && rx_frm_bad) || (frm_r && !err_status_read);
            parerr_r <= (rx_frame_end && par_on && rx_par_bad) || (parerr_r && !err_status_read);
        end
    end

    ubg_skid_buf #(
        .W($bits(ubg_rx_word_t)),
        .DEPTH(RXBUF_DEPTH)
    ) u_rxbuf (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .in_valid(rx_frame_end),
        .in_ready(buf_ready),
        .in_data(push_word),
        .out_valid(rx_out_valid),
        .out_ready(rx_out_ready),
        .out_data(rx_out_word)
    );

    // break trigger and flag
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            brk_trig_r <= 1'b0;
            brk_flag_r <= 1'b0;
        end
        else if (!power)
        begin
            brk_trig_r <= 1'b0;
            brk_flag_r <= 1'b0;
        end
        else if (brk_valid)
        begin
            brk_trig_r <= 1'b0;
            brk_flag_r <= 1'b0;
        end
        else if (break_trigger_set)
        begin
            brk_trig_r <= 1'b1;
            brk_flag_r <= 1'b1;
        end
    end

    // transmit side
    ubg_tx_st_t tx_st_r;
    logic [DIV_W-1:0] tx_cnt_r;
    logic tx_ph_r;
    logic [3:0] tx_idx_r;
    logic [10:0] tx_frame_r;
    logic [7:0] tx_buf_r;
    logic tx_buf_full_r;
    logic tx_pin_r;
    logic tx_irq_r;

    wire tx_wr = tx_wr_valid && tx_wr_ready;
    wire tx_half_end = tick && (tx_cnt_r == divisor_field - DIV_ONE);
    wire tx_bit_end = tx_half_end && tx_ph_r;
    wire [3:0] tx_last = par_on ? TX_LAST_P : TX_LAST_NP;
    wire tx_done = (tx_st_r == TX_SEND) && tx_bit_end && (tx_idx_r == tx_last);
    wire tx_load = tx_buf_full_r && ((tx_st_r == TX_IDLE) || tx_done);
    wire [10:0] tx_frame_nxt = par_on
        ? {1'b1, par_bit(async_mode_reg.parity, tx_buf_r), tx_buf_r, 1'b0}
        : {1'b1, 1'b1, tx_buf_r, 1'b0};

    assign tx_wr_ready = tx_on && !tx_buf_full_r;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_cnt_r <= '0;
            tx_ph_r <= 1'b0;
        end
        else if (!tx_on)
        begin
            tx_cnt_r <= '0;
            tx_ph_r <= 1'b0;
        end
        else if (tx_load)
        begin
            tx_cnt_r <= '0;
            tx_ph_r <= 1'b0;
        end
        else if (tick)
        begin
            // free runs when idle after the last frame
            tx_cnt_r <= tx_half_end ? '0 : tx_cnt_r + 1'b1;
            tx_ph_r <= tx_half_end ? !tx_ph_r : tx_ph_r;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_st_r <= TX_IDLE;
            tx_idx_r <= '0;
            tx_frame_r <= '1;
            tx_buf_r <= '0;
            tx_buf_full_r <= 1'b0;
            tx_pin_r <= 1'b1;
            tx_irq_r <= 1'b0;
        end
        else if (!tx_on)
        begin
            tx_st_r <= TX_IDLE;
            tx_idx_r <= '0;
            tx_buf_full_r <= 1'b0;
            tx_pin_r <= 1'b1;
            tx_irq_r <= 1'b0;
        end
        else
        begin
            tx_irq_r <= tx_done;
            if (tx_wr)
            begin
                tx_buf_r <= tx_wr_data;
            end
            tx_buf_full_r <= tx_wr || (tx_buf_full_r && !tx_load);
            if (tx_load)
            begin
                tx_st_r <= TX_SEND;
                tx_idx_r <= '0;
                tx_frame_r <= tx_frame_nxt;
                tx_pin_r <= tx_frame_nxt[0];
            end
            else if (tx_done)
            begin
                tx_st_r <= TX_IDLE;
                tx_pin_r <= 1'b1;
            end
            else if (tx_st_r == TX_SEND && tx_bit_end)
            begin
                tx_idx_r <= tx_idx_r + 1'b1;
                tx_pin_r <= tx_frame_r[tx_idx_r + 1'b1];
            end
        end
    end

    assign serial_tx_pin = tx_pin_r;
    assign tx_complete_irq = tx_irq_r;
    assign rx_complete_irq = rx_irq_r;
    assign rx_buffer_reg = rx_buf_r;

    always_comb
    begin
        async_control_reg = '0;
        async_control_reg[CTL_FLAG_BIT] = brk_flag_r;
        async_control_reg[CTL_TRIG_BIT] = brk_trig_r;
        rx_error_status_reg = '0;
        rx_error_status_reg[ERR_OVR_BIT] = ovr_r;
        rx_error_status_reg[ERR_FRM_BIT] = frm_r;
        rx_error_status_reg[ERR_PAR_BIT] = parerr_r;
    end
endmodule // ubg_top
`default_nettype wire

// file: testbench/ubg_lin_node.sv
`timescale 1ns/10ps
`default_nettype none
module ubg_lin_node
(
    input wire logic clk_sys,
    input wire logic tx_pin,
    input wire logic send_go,
    input wire logic [15:0] send_bits,
    input wire logic [4:0] send_len,
    input wire logic [8:0] bit_cyc,
    output logic rx_line,
    output logic busy,
    output logic got_valid,
    output logic [8:0] got_word
);
    initial
    begin
        rx_line = 1'b1;
        busy = 1'b0;
        got_valid = 1'b0;
        got_word = '0;
    end
    // lsb first, then the bus falls back to its recessive high level
    always @(posedge clk_sys)
    begin
        if (send_go)
        begin
            busy <= 1'b1;
            for (int i = 0; i < send_len; i++)
            begin
                rx_line <= send_bits[i];
                repeat (bit_cyc) @(posedge clk_sys);
            end
            rx_line <= 1'b1;
            busy <= 1'b0;
        end
    end
    // samples mid-bit: 8 data bits, then parity or stop into bit 8
    always @(negedge tx_pin)
    begin
        repeat (bit_cyc / 2) @(posedge clk_sys);
        for (int i = 0; i < 9; i++)
        begin
            repeat (bit_cyc) @(posedge clk_sys);
            got_word[i] <= tx_pin;
        end
        got_valid <= 1'b1;
        @(posedge clk_sys);
        got_valid <= 1'b0;
        wait (tx_pin);
    end
endmodule // ubg_lin_node
`default_nettype wire

// file: testbench/ubg_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ubg_top_chk
    import ubg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire ubg_mode_t async_mode_reg,
    input wire logic [SEL_W-1:0] base_clock_select_field,
    input wire logic [DIV_W-1:0] divisor_field,
    input wire logic break_trigger_set,
    input wire logic tx_wr_valid,
    input wire logic tx_wr_ready,
    input wire logic serial_tx_pin,
    input wire logic base_clock,
    input wire logic rx_complete_irq,
    input wire logic rx_out_valid,
    input wire logic [7:0] rx_buffer_reg,
    input wire logic [7:0] async_control_reg,
    input wire logic [7:0] rx_error_status_reg
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    logic pin_q_r;
    logic [12:0] run_r;
    wire logic armed = async_control_reg[CTL_TRIG_BIT];
    wire logic [12:0] bit_len = {4'h0, divisor_field, 1'b0};
    // length of the current level run on the tx pin
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_q_r <= 1'b1;
            run_r <= '0;
        end
        else
        begin
            pin_q_r <= serial_tx_pin;
            run_r <= (serial_tx_pin != pin_q_r) ? 13'h0001 : run_r + 13'h0001;
        end
    end
    sequence s_wr_take;
        tx_wr_valid && tx_wr_ready;
    endsequence
    sequence s_brk_done;
        $fell(armed) && async_mode_reg.power;
    endsequence
    a_clk_gated_off: assert property (!async_mode_reg.power |-> !base_clock)
        else $error("base clock runs while unpowered");
    a_clk_undivided: assert property (async_mode_reg.power && $past(async_mode_reg.power, 2)
        && base_clock_select_field == 4'h0 |-> base_clock)
        else $error("base clock missing at select zero");
    a_ready_gated: assert property (tx_wr_ready |-> async_mode_reg.power && async_mode_reg.txe)
        else $error("transmit write accepted while disabled");
    a_take_drops_rdy: assert property (s_wr_take |=> !tx_wr_ready)
        else $error("transmit ready stays up after a write");
    a_bit_width: assert property (serial_tx_pin && !pin_q_r && base_clock_select_field == 4'h0
        |-> (run_r % bit_len) == 13'h0000)
        else $error("low run on tx pin not whole bits");
    a_ctl_layout: assert property (async_control_reg[5:0] == 6'h00
        && async_control_reg[CTL_FLAG_BIT] == armed)
        else $error("control register layout wrong");
    a_trig_sets: assert property (break_trigger_set && async_mode_reg.power |=> armed)
        else $error("break trigger did not arm");
    a_power_clears: assert property (!async_mode_reg.power |=> async_control_reg[7:6] == 2'b00)
        else $error("break bits survive power down");
    a_brk_no_err: assert property (armed |=>
        (rx_error_status_reg[2:0] & ~$past(rx_error_status_reg[2:0])) == 3'h0)
        else $error("error flagged in break mode");
    a_brk_buf_kept: assert property (armed |=> $stable(rx_buffer_reg) && !$rose(rx_out_valid))
        else $error("break mode wrote receive data");
    a_brk_end_irq: assert property (s_brk_done |-> ##[0:1] rx_complete_irq)
        else $error("no irq at valid break end");
    a_irq_single: assert property (rx_complete_irq |=> !rx_complete_irq)
        else $error("receive irq longer than one cycle");
endmodule // ubg_top_chk
bind ubg_top ubg_top_chk u_chk (.clk_sys, .arst_n, .async_mode_reg, .base_clock_select_field,
    .divisor_field, .break_trigger_set, .tx_wr_valid, .tx_wr_ready, .serial_tx_pin, .base_clock,
    .rx_complete_irq, .rx_out_valid, .rx_buffer_reg, .async_control_reg, .rx_error_status_reg);
`default_nettype wire

// file: testbench/ubg_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ubg_top_tb
    import ubg_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    ubg_mode_t mode = '0;
    logic [SEL_W-1:0] sel = '0;
    logic [DIV_W-1:0] k = 8'h0d; // 1.3 times a divisor of 10; node and DUT share it, so ten low bits last ten bit times
    logic trig = 1'b0, err_rd = 1'b0, wr_v = 1'b0, rx_rdy = 1'b0, stall = 1'b0, go = 1'b0;
    logic [7:0] wr_d = 8'h00;
    logic [15:0] bits = '0;
    logic [4:0] len = '0;
    logic rx_line, tx_pin, wr_rdy, rx_v, irq_rx, irq_tx, busy, got_v;
    logic [8:0] got_w;
    ubg_rx_word_t rx_w;
    logic [7:0] buf_r, ctl, err, d, last_b;
    logic [8:0] tx_q[$], rx_q[$];
    int num_errors = 0, num_checks = 0, irq_cnt = 0, irq_tx_cnt = 0, seed = 41753;
    initial forever #2 clk_sys = ~clk_sys;
    ubg_top DUT (
        .clk_sys(clk_sys), .arst_n(arst_n), .async_mode_reg(mode),
        .base_clock_select_field(sel), .divisor_field(k), .break_trigger_set(trig),
        .err_status_read(err_rd), .tx_wr_valid(wr_v), .tx_wr_ready(wr_rdy), .tx_wr_data(wr_d),
        .serial_rx_pin(rx_line), .serial_tx_pin(tx_pin), .base_clock(), .tx_complete_irq(irq_tx),
        .rx_complete_irq(irq_rx), .rx_out_valid(rx_v), .rx_out_ready(rx_rdy), .rx_out_word(rx_w),
        .rx_buffer_reg(buf_r), .async_control_reg(ctl), .rx_error_status_reg(err)
    );
    ubg_lin_node u_node (
        .clk_sys(clk_sys), .tx_pin(tx_pin), .send_go(go), .send_bits(bits), .send_len(len),
        .bit_cyc({k, 1'b0}), .rx_line(rx_line), .busy(busy), .got_valid(got_v), .got_word(got_w)
    );
    task automatic chk_w(input string n, input logic [8:0] e, input logic [8:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic par_of(input int pm, input logic [7:0] v);
        return (pm == 0) ? 1'b1 : (pm == 1) ? 1'b0 : (pm == 2) ? ~^v : ^v;
    endfunction
    task automatic send_tx(input logic [7:0] v, input logic [8:0] e);
        int n;
        n = 0;
        @(posedge clk_sys);
        tx_q.push_back(e);
        wr_d <= v;
        wr_v <= 1'b1;
        do
            @(posedge clk_sys);
        while (wr_rdy !== 1'b1 && n++ < 2000);
        wr_v <= 1'b0;
    endtask
    // fixed tail covers filter lag and the registered irq
    task automatic send_rx(input logic [15:0] b, input logic [4:0] l);
        int n;
        n = 0;
        bits <= b;
        len <= l;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        while (busy && n++ < 2000) @(posedge clk_sys);
        repeat (40) @(posedge clk_sys);
    endtask
    task automatic rx_byte(input logic keep);
        d = 8'($random(seed));
        if (keep)
            rx_q.push_back({1'b0, d});
        send_rx({6'h3f, 1'b1, d, 1'b0}, 5'd10);
    endtask
    always @(posedge clk_sys)
    begin
        rx_rdy <= !stall && 1'($random(seed));
        if (got_v === 1'b1)
            chk_w("tx_frame", (tx_q.size() > 0) ? tx_q.pop_front() : 9'hx, got_w);
        if (rx_v === 1'b1 && rx_rdy === 1'b1)
            chk_w("rx_word", (rx_q.size() > 0) ? rx_q.pop_front() : 9'hx,
                {rx_w.par_err | rx_w.frm_err, rx_w.data});
        if (irq_rx === 1'b1)
            irq_cnt++;
        if (irq_tx === 1'b1)
            irq_tx_cnt++;
    end
    initial
    begin
        int n;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        mode <= '{1'b1, 1'b1, 1'b1, PAR_NONE};
        for (int pm = 0; pm < 4; pm++)
        begin
            mode.parity <= ubg_parity_t'(pm);
            for (int i = 0; i < 2; i++)
            begin
                d = (pm == 1 && i == 0) ? 8'h00 : 8'($random(seed));
                send_tx(d, {par_of(pm, d), d});
            end
            n = 0;
            while (tx_q.size() > 0 && n++ < 5000) @(posedge clk_sys);
        end
        // last frame must finish before txe drops, or its tail is cut short
        n = 0;
        while (irq_tx_cnt < 8 && n++ < 2000) @(posedge clk_sys);
        chk_w("tx_irq", 9'h008, 9'(irq_tx_cnt));
        mode.txe <= 1'b0;
        trig <= 1'b1;
        @(posedge clk_sys);
        trig <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk_w("ctl", 9'h0c0, {1'b0, ctl});
        chk_w("wr_rdy", 9'h000, {8'h00, wr_rdy});
        for (int w = 10; w < 12; w++)
        begin
            send_rx(16'h0000, 5'(w));
            chk_w("ctl", (w == 10) ? 9'h0c0 : 9'h000, {1'b0, ctl});
            chk_w("irq", 9'(w - 10), 9'(irq_cnt));
            chk_w("buf", {1'b0, RX_BUF_RESET}, {1'b0, buf_r});
            chk_w("err", 9'h000, {1'b0, err});
        end
        trig <= 1'b1;
        @(posedge clk_sys);
        trig <= 1'b0;
        mode.power <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk_w("ctl", 9'h000, {1'b0, ctl});
        mode <= '{1'b1, 1'b1, 1'b1, PAR_NONE};
        repeat (3) rx_byte(1'b1);
        stall <= 1'b1;
        rx_byte(1'b1);
        rx_byte(1'b1);
        last_b = d;
        rx_byte(1'b0);
        chk_w("buf", {1'b0, last_b}, {1'b0, buf_r});
        chk_w("err", 9'h001, {1'b0, err});
        err_rd <= 1'b1;
        @(posedge clk_sys);
        err_rd <= 1'b0;
        stall <= 1'b0;
        n = 0;
        while (rx_q.size() > 0 && n++ < 2000) @(posedge clk_sys);
        chk_w("err", 9'h000, {1'b0, err});
        close_out();
    end
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        close_out();
    end
endmodule // ubg_top_tb
`default_nettype wire
